// *** design/pcb_cfg.svh ***
// constants of the port control block decoder: indices, fields, timing
`ifndef PCB_CFG_SVH
`define PCB_CFG_SVH

// ----------------------------------------------------------------
// device register indices on the register port
// ----------------------------------------------------------------
`define PCB_IDX_CMD 2'h0
`define PCB_IDX_STATUS 2'h1
`define PCB_IDX_BASE_LO 2'h2
`define PCB_IDX_BASE_HI 2'h3

// ----------------------------------------------------------------
// port command register fields
// ----------------------------------------------------------------
`define PCB_CMD_ERR_BIT 14
`define PCB_CMD_DONE_BIT 11
`define PCB_CMD_BUSY_BIT 7
`define PCB_CMD_CODE_NONE 4'h0
`define PCB_CMD_CODE_GET_BASE 4'h1
`define PCB_CMD_CODE_POLL 4'h2

// ----------------------------------------------------------------
// status word fields and codes
// ----------------------------------------------------------------
`define PCB_STS_TIMEOUT_BIT 7
// arbitrary controller-type code of our own, names no part
`define PCB_CTRL_TYPE 3'h5
`define PCB_ST_RESET 4'h0
`define PCB_ST_PRIMARY_LOAD 4'h1
`define PCB_ST_READY 4'h2
`define PCB_ST_RUNNING 4'h3
`define PCB_ST_BUS_HALTED 4'h5

// ----------------------------------------------------------------
// control block layout and function codes
// ----------------------------------------------------------------
`define PCB_BLOCK_WORDS 4
`define PCB_FN_NOOP 8'h00
`define PCB_FN_START 8'h01

// ----------------------------------------------------------------
// host bus timeout
// ----------------------------------------------------------------
`define PCB_CLK_MHZ 125
`define PCB_BUS_TIMEOUT_NS 10000
`define PCB_BUS_TIMEOUT_CYC ((`PCB_BUS_TIMEOUT_NS * `PCB_CLK_MHZ) / 1000)

// ----------------------------------------------------------------
// host controller APB register offsets
// ----------------------------------------------------------------
`define PCB_APB_CTRL 12'h000
`define PCB_APB_BASE_LO 12'h004
`define PCB_APB_BASE_HI 12'h008
`define PCB_APB_WINDOW 12'h00C
`define PCB_APB_WORD0 12'h010
`define PCB_APB_WORD3 12'h01C
`define PCB_APB_DEV_STS 12'h020
`define PCB_APB_IRQ_STS 12'h024
`define PCB_APB_IRQ_MASK 12'h028
`define PCB_APB_BUSY 12'h02C
`define PCB_IRQ_DONE_BIT 0
`define PCB_IRQ_ERR_BIT 1

`endif

// *** design/pcb_pkg.sv ***
// types shared by both ends of the port control block decoder
package pcb_pkg;
  typedef enum logic [1:0] {
    FT_IDLE = 2'b00,
    FT_REQ = 2'b01,
    FT_DONE = 2'b11
  } pcb_fetch_e;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_WR_LO = 3'b001,
    HS_WR_HI = 3'b011,
    HS_WR_CMD = 3'b010,
    HS_RD_CMD = 3'b110,
    HS_RD_STS = 3'b111
  } pcb_host_e;

  typedef logic [15:0] pcb_word_t;
endpackage

// *** design/pcb_link_if.sv ***
// link between port driver end and adapter end
`timescale 1ns/1ps
`default_nettype none
interface pcb_link_if;
  logic reg_req;
  logic reg_we;
  logic [1:0] reg_idx;
  logic [15:0] reg_wdata;
  logic reg_ack;
  logic [15:0] reg_rdata;
  logic dma_req;
  logic [17:0] dma_addr;
  logic dma_ack;
  logic [15:0] dma_rdata;

  modport dev (
    input reg_req, reg_we, reg_idx, reg_wdata, dma_ack, dma_rdata,
    output reg_ack, reg_rdata, dma_req, dma_addr
  );
  modport hst (
    output reg_req, reg_we, reg_idx, reg_wdata, dma_ack, dma_rdata,
    input reg_ack, reg_rdata, dma_req, dma_addr
  );
endinterface
`default_nettype wire

// *** design/pcb_fetch.sv ***
// reads the four control block words from host memory
`timescale 1ns/1ps
`default_nettype none
`include "pcb_cfg.svh"
module pcb_fetch (
  input wire logic ref_clk_i,  // adapter clock
  input wire logic rst_i,  // async reset, high
  input wire logic start_i,  // begin fetch, pulse
  input wire logic [17:0] base_i,  // block base address
  output logic dma_req_o,  // word request to host bus
  output logic [17:0] dma_addr_o,  // word address
  input wire logic dma_ack_i,  // word returned, pulse
  input wire logic [15:0] dma_rdata_i,  // returned word
  output logic [63:0] words_o,  // fetched words, word 0 low
  output logic done_o,  // all words in, pulse
  output logic timeout_o  // bus timeout, pulse
);
  localparam int TMO = `PCB_BUS_TIMEOUT_CYC;

  pcb_pkg::pcb_fetch_e st_r;
  logic [1:0] idx_r;
  logic [17:0] base_r;
  logic [15:0] tmo_r;
  logic [63:0] words_r;
  logic last_w;
  logic expire_w;

  assign last_w = (idx_r == 2'(`PCB_BLOCK_WORDS - 1));
  assign expire_w = (tmo_r == 16'(TMO - 1));
  assign dma_req_o = (st_r == pcb_pkg::FT_REQ);
  assign dma_addr_o = base_r + {15'h0000, idx_r, 1'b0};
  assign words_o = words_r;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= pcb_pkg::FT_IDLE;
      idx_r <= 2'h0;
      base_r <= 18'h0_0000;
      tmo_r <= 16'h0000;
      words_r <= 64'h0000_0000_0000_0000;
      done_o <= 1'b0;
      timeout_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      timeout_o <= 1'b0;
      unique case (st_r)
        pcb_pkg::FT_IDLE: begin
          if (start_i) begin
            st_r <= pcb_pkg::FT_REQ;
            base_r <= base_i;
            idx_r <= 2'h0;
            tmo_r <= 16'h0000;
          end
        end
        pcb_pkg::FT_REQ: begin
          if (dma_ack_i) begin
            words_r[idx_r*16 +: 16] <= dma_rdata_i;
            idx_r <= idx_r + 2'h1;
            tmo_r <= 16'h0000;
            if (last_w) begin
              st_r <= pcb_pkg::FT_DONE;
            end
          end else if (expire_w) begin
            st_r <= pcb_pkg::FT_IDLE;
            timeout_o <= 1'b1;
          end else begin
            tmo_r <= tmo_r + 16'h0001;
          end
        end
        pcb_pkg::FT_DONE: begin
          st_r <= pcb_pkg::FT_IDLE;
          done_o <= 1'b1;
        end
        default: st_r <= pcb_pkg::FT_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** design/pcb_dev.sv ***
// adapter end: port registers, control block fetch and function decode
// Behaviour
// - timeout flag valid only with error interrupt set
// - host bus timeout during command sets flag
// - error with flag clear means function error
// - status word carries fixed controller-type code
// - four-bit operating state with fixed encodings
// - low base register holds address bits 15:1
// - host writes low base bit zero as zero
// - high base holds bits 17:16, rest zero
// - fetch four sixteen-bit words from base
// - get-base command latches the base address
// - function byte written by host, never modified
// - decode remaining fields by function code
// - function zero does nothing
// - function one starts microcode at given address
// - start address 15:1 from word one
// - start address 23:16 from word two low
// - host keeps start address bit zero clear
// - host loads microcode before start function
`timescale 1ns/1ps
`default_nettype none
`include "pcb_cfg.svh"
module pcb_dev #(
  parameter logic [2:0] CTRL_TYPE = `PCB_CTRL_TYPE  // arbitrary value
) (
  input wire logic ref_clk_i,  // adapter clock
  input wire logic rst_i,  // async reset, high
  pcb_link_if.dev link,  // host side link
  output logic [3:0] op_state_o,  // operating state
  output logic ustart_o,  // start microcode, pulse
  output logic [23:0] ustart_addr_o,  // internal start address
  output logic cmd_err_o  // command error interrupt level
);
  // ----------------------------------------------------------------
  // registers and wires
  // ----------------------------------------------------------------
  logic [15:1] base_lo_r;
  logic [1:0] base_hi_r;
  logic [17:0] cb_base_r;
  logic err_r;
  logic done_r;
  logic busy_r;
  logic tmo_r;
  logic [3:0] code_r;
  logic [3:0] state_r;
  logic [23:0] ustart_addr_r;
  logic ustart_r;
  logic ack_r;
  logic [15:0] rdata_r;
  logic started_r;

  logic wr_w;
  logic rd_w;
  logic [3:0] wcode_w;
  logic issue_w;
  logic get_base_w;
  logic poll_w;
  logic fetch_done_w;
  logic fetch_tmo_w;
  logic [63:0] words_w;
  logic [15:0] word0_w;
  logic [15:0] word1_w;
  logic [15:0] word2_w;
  logic [7:0] fn_w;
  logic fn_noop_w;
  logic fn_start_w;
  logic start_ok_w;
  logic fn_err_w;
  logic clr_err_w;
  logic clr_done_w;
  logic set_err_w;
  logic set_done_w;
  logic [15:0] cmd_word_w;
  logic [15:0] sts_word_w;
  logic [15:0] rmux_w;

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  // one request is answered per two cycles so a held request is not taken twice
  assign wr_w = link.reg_req & link.reg_we & ~ack_r;
  assign rd_w = link.reg_req & ~link.reg_we & ~ack_r;
  assign wcode_w = link.reg_wdata[3:0];
  assign issue_w = wr_w & (link.reg_idx == `PCB_IDX_CMD) & ~busy_r;
  assign get_base_w = issue_w & (wcode_w == `PCB_CMD_CODE_GET_BASE);
  assign poll_w = issue_w & (wcode_w == `PCB_CMD_CODE_POLL);
  assign clr_err_w = wr_w & (link.reg_idx == `PCB_IDX_CMD) & link.reg_wdata[`PCB_CMD_ERR_BIT];
  assign clr_done_w = wr_w & (link.reg_idx == `PCB_IDX_CMD) & link.reg_wdata[`PCB_CMD_DONE_BIT];

  // ----------------------------------------------------------------
  // control block fetch
  // ----------------------------------------------------------------
  pcb_fetch u_fetch (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .start_i(poll_w),
    .base_i(cb_base_r),
    .dma_req_o(link.dma_req),
    .dma_addr_o(link.dma_addr),
    .dma_ack_i(link.dma_ack),
    .dma_rdata_i(link.dma_rdata),
    .words_o(words_w),
    .done_o(fetch_done_w),
    .timeout_o(fetch_tmo_w)
  );

  // ----------------------------------------------------------------
  // function decode, acts only once all words are in
  // ----------------------------------------------------------------
  // the fetched copy is only read; the function byte is never written back
  assign word0_w = words_w[15:0];
  assign word1_w = words_w[31:16];
  assign word2_w = words_w[47:32];
  assign fn_w = word0_w[7:0];
  assign fn_noop_w = (fn_w == `PCB_FN_NOOP);
  assign fn_start_w = (fn_w == `PCB_FN_START);
  // reserved-zero fields checked for the start function
  assign start_ok_w = (word0_w[15:8] == 8'h00) & (word2_w[15:8] == 8'h00);
  assign fn_err_w = fetch_done_w & ~fn_noop_w & ~(fn_start_w & start_ok_w);
  assign set_err_w = fn_err_w | fetch_tmo_w;
  assign set_done_w = fetch_done_w | get_base_w;

  // ----------------------------------------------------------------
  // read-back words
  // ----------------------------------------------------------------
  always_comb begin
    cmd_word_w = 16'h0000;
    cmd_word_w[`PCB_CMD_ERR_BIT] = err_r;
    cmd_word_w[`PCB_CMD_DONE_BIT] = done_r;
    cmd_word_w[`PCB_CMD_BUSY_BIT] = busy_r;
    cmd_word_w[3:0] = code_r;
  end

  always_comb begin
    sts_word_w = 16'h0000;
    // flag is only meaningful while err_r is set; it is cleared along with it
    sts_word_w[`PCB_STS_TIMEOUT_BIT] = tmo_r & err_r;
    sts_word_w[6:4] = CTRL_TYPE;
    sts_word_w[3:0] = state_r;
  end

  assign rmux_w = (link.reg_idx == `PCB_IDX_CMD) ? cmd_word_w :
                  (link.reg_idx == `PCB_IDX_STATUS) ? sts_word_w :
                  (link.reg_idx == `PCB_IDX_BASE_LO) ? {base_lo_r, 1'b0} :
                  {14'h0000, base_hi_r};

  assign link.reg_ack = ack_r;
  assign link.reg_rdata = rdata_r;
  assign op_state_o = state_r;
  assign ustart_o = ustart_r;
  assign ustart_addr_o = ustart_addr_r;
  assign cmd_err_o = err_r;

  // ----------------------------------------------------------------
  // register port answer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      ack_r <= wr_w | rd_w;
      if (rd_w) begin
        rdata_r <= rmux_w;
      end
    end
  end

  // ----------------------------------------------------------------
  // base registers and latched base
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      base_lo_r <= 15'h0000;
      base_hi_r <= 2'h0;
      cb_base_r <= 18'h0_0000;
    end else begin
      if (wr_w & (link.reg_idx == `PCB_IDX_BASE_LO)) begin
        base_lo_r <= link.reg_wdata[15:1];
      end
      if (wr_w & (link.reg_idx == `PCB_IDX_BASE_HI)) begin
        base_hi_r <= link.reg_wdata[1:0];
      end
      if (get_base_w) begin
        cb_base_r <= {base_hi_r, base_lo_r, 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // command flags; a hardware set wins over a same-cycle clear
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      err_r <= 1'b0;
      done_r <= 1'b0;
      busy_r <= 1'b0;
      tmo_r <= 1'b0;
      code_r <= `PCB_CMD_CODE_NONE;
    end else begin
      if (issue_w) begin
        code_r <= wcode_w;
      end
      if (poll_w) begin
        busy_r <= 1'b1;
      end else if (fetch_done_w | fetch_tmo_w) begin
        busy_r <= 1'b0;
      end
      if (set_err_w) begin
        err_r <= 1'b1;
        tmo_r <= fetch_tmo_w;
      end else if (clr_err_w) begin
        err_r <= 1'b0;
        tmo_r <= 1'b0;
      end
      if (set_done_w) begin
        done_r <= 1'b1;
      end else if (clr_done_w) begin
        done_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // operating state and start function
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= `PCB_ST_RESET;
      started_r <= 1'b0;
      ustart_r <= 1'b0;
      ustart_addr_r <= 24'h00_0000;
    end else begin
      ustart_r <= 1'b0;
      if (!started_r) begin
        started_r <= 1'b1;
        state_r <= `PCB_ST_READY;
      end else if (fetch_tmo_w) begin
        state_r <= `PCB_ST_BUS_HALTED;
      end else if (fetch_done_w & fn_start_w & start_ok_w) begin
        // host has placed microcode beforehand; bit zero forced even
        ustart_addr_r <= {word2_w[7:0], word1_w[15:1], 1'b0};
        ustart_r <= 1'b1;
        state_r <= `PCB_ST_RUNNING;
      end
    end
  end
endmodule
`default_nettype wire

// *** design/pcb_host.sv ***
// port driver end: APB registers, command sequencer, block memory window
`timescale 1ns/1ps
`default_nettype none
`include "pcb_cfg.svh"
module pcb_host (
  input wire logic ref_clk_i,  // clock
  input wire logic rst_i,  // async reset, high
  input wire logic psel,  // APB select
  input wire logic penable,  // APB enable
  input wire logic pwrite,  // APB direction
  input wire logic [11:0] paddr,  // APB byte address
  input wire logic [31:0] pwdata,  // APB write data
  output logic [31:0] prdata,  // APB read data
  output logic pready,  // APB ready
  output logic pslverr,  // APB error
  output logic irq_o,  // interrupt level
  pcb_link_if.hst link  // adapter side link
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pcb_pkg::pcb_host_e st_r;
  logic [15:0] base_lo_r;
  logic [15:0] base_hi_r;
  logic [17:0] win_r;
  pcb_pkg::pcb_word_t blk_r [4];
  logic [15:0] dev_sts_r;
  logic [1:0] irq_sts_r;
  logic [1:0] irq_mask_r;
  logic dma_ack_r;
  logic [15:0] dma_rdata_r;
  logic poll_r;

  logic acc_w;
  logic wr_w;
  logic hit_w;
  logic [17:0] off_w;
  logic go_base_w;
  logic go_poll_w;
  logic set_done_w;
  logic set_err_w;
  logic [1:0] irq_set_w;
  logic [31:0] rmux_w;
  logic cmd_fin_w;

  // ----------------------------------------------------------------
  // APB decode; zero wait states
  // ----------------------------------------------------------------
  assign acc_w = psel & penable;
  assign wr_w = acc_w & pwrite;
  assign pready = 1'b1;
  assign hit_w = (paddr[1:0] == 2'h0) & (paddr <= `PCB_APB_BUSY);
  assign pslverr = acc_w & ~hit_w;
  assign go_base_w = wr_w & (paddr == `PCB_APB_CTRL) & pwdata[0] & (st_r == pcb_pkg::HS_IDLE);
  assign go_poll_w = wr_w & (paddr == `PCB_APB_CTRL) & pwdata[1] & (st_r == pcb_pkg::HS_IDLE);

  always_comb begin
    rmux_w = 32'h0000_0000;
    unique case (paddr)
      `PCB_APB_BASE_LO: rmux_w = {16'h0000, base_lo_r};
      `PCB_APB_BASE_HI: rmux_w = {16'h0000, base_hi_r};
      `PCB_APB_WINDOW: rmux_w = {14'h0000, win_r};
      `PCB_APB_DEV_STS: rmux_w = {16'h0000, dev_sts_r};
      `PCB_APB_IRQ_STS: rmux_w = {30'h0000_0000, irq_sts_r};
      `PCB_APB_IRQ_MASK: rmux_w = {30'h0000_0000, irq_mask_r};
      `PCB_APB_BUSY: rmux_w = {31'h0000_0000, st_r != pcb_pkg::HS_IDLE};
      default: begin
        if (paddr >= `PCB_APB_WORD0 && paddr <= `PCB_APB_WORD3) begin
          rmux_w = {16'h0000, blk_r[paddr[3:2]]};
        end
      end
    endcase
  end
  assign prdata = (acc_w & ~pwrite) ? rmux_w : 32'h0000_0000;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      base_lo_r <= 16'h0000;
      base_hi_r <= 16'h0000;
      win_r <= 18'h0_0000;
      irq_mask_r <= 2'h0;
      for (int i = 0; i < 4; i++) begin
        blk_r[i] <= 16'h0000;
      end
    end else if (wr_w) begin
      // word alignment and reserved-zero bits are kept by the driver
      if (paddr == `PCB_APB_BASE_LO) base_lo_r <= {pwdata[15:1], 1'b0};
      if (paddr == `PCB_APB_BASE_HI) base_hi_r <= {14'h0000, pwdata[1:0]};
      if (paddr == `PCB_APB_WINDOW) win_r <= {pwdata[17:1], 1'b0};
      if (paddr == `PCB_APB_IRQ_MASK) irq_mask_r <= pwdata[1:0];
      // block words are only ever written by the driver
      if (paddr >= `PCB_APB_WORD0 && paddr <= `PCB_APB_WORD3) begin
        blk_r[paddr[3:2]] <= pwdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupts: sticky, write one to clear, set wins
  // ----------------------------------------------------------------
  assign irq_set_w = {set_err_w, set_done_w};
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_sts_r <= 2'h0;
    end else begin
      irq_sts_r <= irq_set_w |
        (irq_sts_r & ~((wr_w && paddr == `PCB_APB_IRQ_STS) ? pwdata[1:0] : 2'h0));
    end
  end
  assign irq_o = |(irq_sts_r & irq_mask_r);

  // ----------------------------------------------------------------
  // command sequencer over the register port
  // ----------------------------------------------------------------
  assign link.reg_req = (st_r != pcb_pkg::HS_IDLE);
  assign link.reg_we = (st_r == pcb_pkg::HS_WR_LO) | (st_r == pcb_pkg::HS_WR_HI) |
                       (st_r == pcb_pkg::HS_WR_CMD);
  assign link.reg_idx = (st_r == pcb_pkg::HS_WR_LO) ? `PCB_IDX_BASE_LO :
                        (st_r == pcb_pkg::HS_WR_HI) ? `PCB_IDX_BASE_HI :
                        (st_r == pcb_pkg::HS_RD_STS) ? `PCB_IDX_STATUS : `PCB_IDX_CMD;
  // command write also clears stale done and error flags
  assign link.reg_wdata = (st_r == pcb_pkg::HS_WR_LO) ? base_lo_r :
                          (st_r == pcb_pkg::HS_WR_HI) ? base_hi_r :
                          {1'b0, 1'b1, 2'h0, 1'b1, 7'h00,
                           poll_r ? `PCB_CMD_CODE_POLL : `PCB_CMD_CODE_GET_BASE};
  assign cmd_fin_w = link.reg_ack & (st_r == pcb_pkg::HS_RD_CMD) &
                     (link.reg_rdata[`PCB_CMD_DONE_BIT] | link.reg_rdata[`PCB_CMD_ERR_BIT]);
  assign set_done_w = link.reg_ack & (st_r == pcb_pkg::HS_RD_STS);
  // error reason (timeout or function) is left in the saved status word
  assign set_err_w = set_done_w & poll_r & dev_sts_r[`PCB_CMD_ERR_BIT];

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= pcb_pkg::HS_IDLE;
      poll_r <= 1'b0;
      dev_sts_r <= 16'h0000;
    end else begin
      unique case (st_r)
        pcb_pkg::HS_IDLE: begin
          if (go_base_w) begin
            poll_r <= 1'b0;
            st_r <= pcb_pkg::HS_WR_LO;
          end else if (go_poll_w) begin
            poll_r <= 1'b1;
            st_r <= pcb_pkg::HS_WR_CMD;
          end
        end
        pcb_pkg::HS_WR_LO: if (link.reg_ack) st_r <= pcb_pkg::HS_WR_HI;
        pcb_pkg::HS_WR_HI: if (link.reg_ack) st_r <= pcb_pkg::HS_WR_CMD;
        pcb_pkg::HS_WR_CMD: if (link.reg_ack) st_r <= pcb_pkg::HS_RD_CMD;
        pcb_pkg::HS_RD_CMD: begin
          if (cmd_fin_w) begin
            dev_sts_r <= link.reg_rdata;
            st_r <= pcb_pkg::HS_RD_STS;
          end
        end
        pcb_pkg::HS_RD_STS: begin
          if (link.reg_ack) begin
            // keep the error bit of the command word alongside the status byte
            dev_sts_r <= {dev_sts_r[15:8], link.reg_rdata[7:0]};
            st_r <= pcb_pkg::HS_IDLE;
          end
        end
        default: st_r <= pcb_pkg::HS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // memory window answering block reads; outside it no answer comes
  // ----------------------------------------------------------------
  assign off_w = link.dma_addr - win_r;
  assign link.dma_ack = dma_ack_r;
  assign link.dma_rdata = dma_rdata_r;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dma_ack_r <= 1'b0;
      dma_rdata_r <= 16'h0000;
    end else begin
      dma_ack_r <= link.dma_req & ~dma_ack_r & (off_w[17:3] == 15'h0000);
      if (link.dma_req) begin
        dma_rdata_r <= blk_r[off_w[2:1]];
      end
    end
  end
endmodule
`default_nettype wire

// *** bench/pcb_link_props.sv ***
// checker of the register and block-fetch link between the two ends
`timescale 1ns/1ps
`default_nettype none
module pcb_link_props (
  input wire logic ref_clk_i,  // clock
  input wire logic rst_i,  // reset
  input wire logic reg_req,  // register request
  input wire logic reg_we,  // direction
  input wire logic [1:0] reg_idx,  // register index
  input wire logic [15:0] reg_wdata,  // write data
  input wire logic reg_ack,  // register answer
  input wire logic [15:0] reg_rdata,  // read data
  input wire logic dma_req,  // word request
  input wire logic [17:0] dma_addr,  // word address
  input wire logic dma_ack  // word answer
);
  // ----
  // unanswered word wait, bounded by the bus timeout
  // ----
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic [11:0] wait_r;
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i) wait_r <= 12'h000;
    else wait_r <= (dma_req && !dma_ack) ? wait_r + 12'h001 : 12'h000;
  sequence word_step;
    dma_ack ##1 dma_req;
  endsequence
  a_ack_pulse: assert property (reg_ack |=> !reg_ack)
    else $error("register answer longer than one cycle");
  a_ack_follows_req: assert property (reg_req && !reg_ack |=> reg_ack)
    else $error("register request not answered next cycle");
  a_req_held: assert property (reg_req && !reg_ack |=> reg_req && $stable({reg_we, reg_idx, reg_wdata}))
    else $error("register request changed before answer");
  a_rdata_holds: assert property (!reg_ack |-> $stable(reg_rdata))
    else $error("read data changed without answer");
  a_dma_addr_held: assert property (dma_req && !dma_ack |=> !dma_req || $stable(dma_addr))
    else $error("word address moved while waiting");
  a_addr_step: assert property (word_step |-> dma_addr == $past(dma_addr) + 18'h0_0002)
    else $error("next word address not two bytes on");
  a_ack_has_req: assert property (dma_ack |-> $past(dma_req))
    else $error("word answer without request");
  a_wait_bounded: assert property (wait_r < 12'h4E4)
    else $error("word request outlived the bus timeout");
endmodule
`default_nettype wire

// *** bench/port_control_block_decoder_tb_top.sv ***
// testbench: both ends joined, driven over APB
`timescale 1ns/1ps
`default_nettype none
module port_control_block_decoder_tb_top;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd_v;
  logic pready, pslverr, irq_o, ustart_o, cmd_err_o, err_v;
  logic [3:0] op_state_o;
  logic [23:0] ustart_addr_o;
  logic [15:0] bad_fn [2] = '{16'h0002, 16'h0101};
  int bad_count = 0, n_checks = 0, cyc = 0, n_start = 0;
  pcb_link_if link ();
  pcb_host pcb_host_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_o(irq_o), .link(link));
  pcb_dev #(.CTRL_TYPE(3'h5)) pcb_dev_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(link),
    .op_state_o(op_state_o), .ustart_o(ustart_o), .ustart_addr_o(ustart_addr_o),
    .cmd_err_o(cmd_err_o));
  pcb_link_props pcb_link_props_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_req(link.reg_req),
    .reg_we(link.reg_we), .reg_idx(link.reg_idx), .reg_wdata(link.reg_wdata),
    .reg_ack(link.reg_ack), .reg_rdata(link.reg_rdata), .dma_req(link.dma_req),
    .dma_addr(link.dma_addr), .dma_ack(link.dma_ack));
  // ----
  // clock, hang guard, start pulse count
  // ----
  always #4 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (ustart_o === 1'b1) n_start++;
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do @(posedge ref_clk_i); while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic idle();
    do xfer(1'b0, 12'h02C, 32'h0000_0000); while (rd_v[0] !== 1'b0);
  endtask
  // window, block words, poll command, then the saved device word
  task automatic poll(input logic [15:0] w0, w1, w2, input logic [31:0] win);
    xfer(1'b1, 12'h00C, win);
    xfer(1'b1, 12'h010, 32'(w0));
    xfer(1'b1, 12'h014, 32'(w1));
    xfer(1'b1, 12'h018, 32'(w2));
    xfer(1'b1, 12'h000, 32'h0000_0002);
    idle();
    xfer(1'b0, 12'h020, 32'h0000_0000);
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  initial begin
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    xfer(1'b1, 12'h004, 32'h0000_1234);
    xfer(1'b1, 12'h008, 32'h0000_0002);
    xfer(1'b1, 12'h000, 32'h0000_0001);
    idle();
    chk(32'(op_state_o), 32'h0000_0002);
    xfer(1'b1, 12'h028, 32'h0000_0003);
    poll(16'h0000, 16'hFFFE, 16'h0000, 32'h0002_1234);
    chk(32'({rd_v[14], rd_v[7:0]}), 32'h0000_0052);
    chk(32'(n_start), 32'h0000_0000);
    chk(32'(irq_o), 32'h0000_0001);
    xfer(1'b1, 12'h024, 32'h0000_0003);
    // the clear lands at the access edge; look once it has settled
    @(negedge ref_clk_i);
    chk(32'(irq_o), 32'h0000_0000);
    xfer(1'b1, 12'h028, 32'h0000_0000);
    poll(16'h0001, 16'hABCC, 16'h005A, 32'h0002_1234);
    chk(32'(ustart_addr_o), 32'h005A_ABCC);
    chk(32'(n_start), 32'h0000_0001);
    chk(32'({rd_v[14], rd_v[7:0]}), 32'h0000_0053);
    chk(32'(irq_o), 32'h0000_0000);
    xfer(1'b0, 12'h024, 32'h0000_0000);
    chk(32'(rd_v[0]), 32'h0000_0001);
    foreach (bad_fn[i]) begin
      poll(bad_fn[i], 16'h0000, 16'h0000, 32'h0002_1234);
      chk(32'({rd_v[14], rd_v[7]}), 32'h0000_0002);
    end
    chk(32'(cmd_err_o), 32'h0000_0001);
    chk(32'(n_start), 32'h0000_0001);
    poll(16'h0001, 16'h0000, 16'h0000, 32'h0000_0100);
    chk(32'({rd_v[14], rd_v[7], rd_v[3:0]}), 32'h0000_0035);
    chk(32'(op_state_o), 32'h0000_0005);
    xfer(1'b0, 12'h030, 32'h0000_0000);
    chk(32'(err_v), 32'h0000_0001);
    end_of_test();
  end
endmodule
`default_nettype wire
